//--- lhiac_pkg.sv
/*
  Constants, field layouts and carrier types for the attention and
  initialization control block of a LAN controller.
  Assumes a 24-bit memory address space and a 16-bit shared memory word.
*/
package lhiac_pkg;

  // ----------------------------------------------------------------
  // memory map of the initialization root
  // ----------------------------------------------------------------
  localparam logic [23:0] ROOT_ADDR    = 24'hfffff6;
  localparam logic [23:0] INTERMEDIATE_POINTER_LO_OFS  = 24'h000006;
  localparam logic [23:0] INTERMEDIATE_POINTER_HI_OFS  = 24'h000008;
  localparam logic [23:0] SCB_OFS_OFS  = 24'h000002;
  localparam logic [23:0] BASE_LO_OFS  = 24'h000004;
  localparam logic [23:0] BASE_HI_OFS  = 24'h000006;
  localparam logic [23:0] STAT_OFS     = 24'h000000;
  localparam logic [23:0] CMD_OFS      = 24'h000002;
  localparam logic [23:0] BYTE_STEP    = 24'h000001;
  localparam logic [7:0]  BUSY_CLEAR   = 8'h00;

  // ----------------------------------------------------------------
  // status bit positions inside the four interrupt flags
  // ----------------------------------------------------------------
  localparam int STAT_CX  = 3;
  localparam int STAT_FR  = 2;
  localparam int STAT_CNR = 1;
  localparam int STAT_RNR = 0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ack;
    logic       rsv0;
    logic [2:0] cu_cmd;
    logic       rsv1;
    logic [2:0] ru_cmd;
    logic [3:0] rsv2;
  } lhiac_cmd_s;

  typedef struct packed {
    logic [3:0] stat;
    logic       rsv0;
    logic [2:0] cu_state;
    logic       rsv1;
    logic [2:0] ru_state;
    logic [3:0] rsv2;
  } lhiac_stat_s;

  typedef struct packed {
    logic [3:0] fifo_limit;
    logic       ready_mode;
    logic       save_bad;
    logic [2:0] addr_len;
  } lhiac_cfg_s;

  typedef struct packed {
    logic [23:0] addr;
    logic        we;
    logic        byte_op;
    logic [15:0] wdata;
  } lhiac_mem_s;

  localparam lhiac_cfg_s CFG_RESET = '{fifo_limit: 4'h8, ready_mode: 1'b0,
                                       save_bad: 1'b0, addr_len: 3'h6};

  typedef enum logic [3:0] {
    S_RESET_WAIT, S_RD_BUS_WIDTH_SELECT, S_RD_INTERMEDIATE_POINTER_LO, S_RD_INTERMEDIATE_POINTER_HI, S_RD_SCB_OFS,
    S_RD_BASE_LO, S_RD_BASE_HI, S_WR_BUSY, S_CA_IDLE, S_RD_CMD, S_ACCEPT,
    S_INT_LOW, S_WR_STAT, S_WR_CMD, S_INT_HIGH
  } lhiac_state_e;

endpackage

//--- lhiac_ca_edge.sv
/*
  Attention strobe synchronizer, falling-edge detector and service latch.
  Assumes the strobe is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module lhiac_ca_edge
  import lhiac_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic channel_attention,
  input  wire logic latch_clr,
  output logic      ca_latched
);

  logic sync1_reg, sync2_reg, prev_reg, fall_reg, latch_reg;
  logic fall_next, latch_next;

  always_comb begin
    fall_next  = prev_reg & ~sync2_reg;
    latch_next = fall_reg | (latch_reg & ~latch_clr);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
      fall_reg  <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      sync1_reg <= channel_attention;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      fall_reg  <= fall_next;
      latch_reg <= latch_next;
    end
  end

  assign ca_latched = latch_reg;

  property p_edge_latch;
    @(posedge core_clk) disable iff (sys_rst)
      fall_reg |=> latch_reg;
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("attention edge not latched");

endmodule // lhiac_ca_edge

//--- lhiac_ctl.sv
/*
  Attention handling, initialization walk and first configuration group.
  Assumes a memory port that holds mem_rdy while mem_req is high, and
  command and receive units that report busy while doing descriptor work.
*/
`timescale 1ns/1ps
module lhiac_ctl
  import lhiac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        channel_attention,
  input  wire logic        bus_grant,
  input  wire logic        mem_rdy,
  input  wire logic [15:0] mem_rdata,
  input  wire logic        cu_busy,
  input  wire logic        ru_busy,
  input  wire logic [2:0]  cu_state,
  input  wire logic [2:0]  ru_state,
  input  wire logic [3:0]  unit_events,
  input  wire logic        cfg_load,
  input  wire lhiac_cfg_s  cfg_in,
  input  wire logic        ia_loaded,
  input  wire logic [3:0]  fifo_level,
  output logic             bus_req,
  output logic             mem_req,
  output lhiac_mem_s       mem_op,
  output logic             int_out,
  output logic             cu_cmd_valid,
  output logic [2:0]       cu_cmd,
  output logic             ru_cmd_valid,
  output logic [2:0]       ru_cmd,
  output logic             bus8_mode,
  output lhiac_cfg_s       cfg_out,
  output logic             broadcast_only,
  output logic             fifo_xfer_req
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lhiac_state_e state_reg, state_next;
  lhiac_mem_s   op_reg, op_next;
  lhiac_cmd_s   cmd_reg, cmd_next;
  lhiac_cfg_s   cfg_reg, cfg_next;
  logic [23:0]  intermediate_pointer_reg, intermediate_pointer_next, base_reg, base_next;
  logic [15:0]  scb_ofs_reg, scb_ofs_next, data_reg, data_next;
  logic [3:0]   pend_reg, pend_next, rep_reg, rep_next;
  logic         req_reg, req_next, half_reg, half_next;
  logic         bus8_reg, bus8_next, int_reg, int_next;
  logic         busreq_reg, busreq_next, clrcmd_reg, clrcmd_next;
  logic         cu_acc_reg, cu_acc_next, ru_acc_reg, ru_acc_next;
  logic         cuv_reg, cuv_next, ruv_reg, ruv_next;
  logic         bcast_reg, bcast_next, fifo_reg, fifo_next;
  logic         rdy_s1_reg, rdy_s2_reg;
  logic         ca_latched, ca_clr, rdy_eff, acc_fire, acc_done, seq_busy;
  logic [15:0]  rd_word;
  logic [23:0]  scb_addr;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_access(input lhiac_state_e s);
    return s inside {S_RD_BUS_WIDTH_SELECT, S_RD_INTERMEDIATE_POINTER_LO, S_RD_INTERMEDIATE_POINTER_HI, S_RD_SCB_OFS,
                     S_RD_BASE_LO, S_RD_BASE_HI, S_WR_BUSY, S_RD_CMD,
                     S_WR_STAT, S_WR_CMD};
  endfunction

  function automatic lhiac_mem_s op_of(input lhiac_state_e s,
                                       input logic [23:0] intermediate_pointer,
                                       input logic [23:0] system_control_block,
                                       input lhiac_stat_s st);
    lhiac_mem_s o;
    o = '{addr: ROOT_ADDR, we: 1'b0, byte_op: 1'b0, wdata: 16'h0000};
    unique case (s)
      S_RD_BUS_WIDTH_SELECT:  o.byte_op = 1'b1;
      S_RD_INTERMEDIATE_POINTER_LO: o.addr = ROOT_ADDR + INTERMEDIATE_POINTER_LO_OFS;
      S_RD_INTERMEDIATE_POINTER_HI: o.addr = ROOT_ADDR + INTERMEDIATE_POINTER_HI_OFS;
      S_RD_SCB_OFS: o.addr = intermediate_pointer + SCB_OFS_OFS;
      S_RD_BASE_LO: o.addr = intermediate_pointer + BASE_LO_OFS;
      S_RD_BASE_HI: o.addr = intermediate_pointer + BASE_HI_OFS;
      S_WR_BUSY: begin
        o.addr    = intermediate_pointer;
        o.we      = 1'b1;
        o.byte_op = 1'b1;
        o.wdata   = {8'h00, BUSY_CLEAR};
      end
      S_RD_CMD:     o.addr = system_control_block + CMD_OFS;
      S_WR_STAT: begin
        o.addr  = system_control_block + STAT_OFS;
        o.we    = 1'b1;
        o.wdata = st;
      end
      S_WR_CMD: begin
        o.addr = system_control_block + CMD_OFS;
        o.we   = 1'b1;
      end
      default: o = o;
    endcase
    return o;
  endfunction

  // ----------------------------------------------------------------
  // attention edge and ready handling
  // ----------------------------------------------------------------
  lhiac_ca_edge u_ca_edge (
    .core_clk          (core_clk),
    .sys_rst           (sys_rst),
    .channel_attention (channel_attention),
    .latch_clr         (ca_clr),
    .ca_latched        (ca_latched)
  );

  assign scb_addr = base_reg + {8'h00, scb_ofs_reg};
  assign rdy_eff  = cfg_reg.ready_mode ? mem_rdy : rdy_s2_reg;
  assign acc_fire = req_reg & rdy_eff;
  assign acc_done = acc_fire & (op_reg.byte_op | ~bus8_reg | half_reg);
  assign seq_busy = !(state_reg inside {S_RESET_WAIT, S_CA_IDLE});
  // the first strobe starts init; it must not leave a stale latch behind
  assign ca_clr   = (state_reg inside {S_RESET_WAIT, S_CA_IDLE}) & ca_latched;
  assign rd_word  = (op_reg.byte_op | bus8_reg) ?
                    (half_reg ? {mem_rdata[7:0], data_reg[7:0]} : {8'h00, mem_rdata[7:0]})
                    : mem_rdata;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    op_next     = op_reg;
    cmd_next    = cmd_reg;
    cfg_next    = cfg_reg;
    intermediate_pointer_next   = intermediate_pointer_reg;
    base_next   = base_reg;
    scb_ofs_next = scb_ofs_reg;
    data_next   = data_reg;
    pend_next   = pend_reg;
    rep_next    = rep_reg;
    req_next    = req_reg;
    half_next   = half_reg;
    bus8_next   = bus8_reg;
    int_next    = int_reg;
    clrcmd_next = clrcmd_reg;
    cu_acc_next = cu_acc_reg;
    ru_acc_next = ru_acc_reg;
    cuv_next    = 1'b0;
    ruv_next    = 1'b0;
    bcast_next  = bcast_reg & ~ia_loaded;
    fifo_next   = fifo_level >= cfg_reg.fifo_limit;
    busreq_next = seq_busy | fifo_next;
    if (cfg_load) begin
      cfg_next = cfg_in;
    end

    // access engine; the grant must be held for a whole sequence
    if (!bus_grant) begin
      req_next  = 1'b0;
      half_next = 1'b0;
    end else if (acc_fire) begin
      req_next  = 1'b0;
      data_next = rd_word;
      half_next = !acc_done;
    end else if (is_access(state_reg) && !req_reg && !rdy_eff) begin
      req_next = 1'b1;
      op_next  = op_of(state_reg, intermediate_pointer_reg, scb_addr,
                       '{stat: pend_reg, rsv0: 1'b0, cu_state: cu_state,
                         rsv1: 1'b0, ru_state: ru_state, rsv2: 4'h0});
      if (half_reg) begin
        op_next.addr = op_next.addr + BYTE_STEP;
      end
    end

    unique case (state_reg)
      S_RESET_WAIT: if (ca_latched) state_next = S_RD_BUS_WIDTH_SELECT;
      S_RD_BUS_WIDTH_SELECT: if (acc_done) begin
        bus8_next  = mem_rdata[0];
        state_next = S_RD_INTERMEDIATE_POINTER_LO;
      end
      S_RD_INTERMEDIATE_POINTER_LO: if (acc_done) begin
        intermediate_pointer_next[15:0] = rd_word;
        state_next      = S_RD_INTERMEDIATE_POINTER_HI;
      end
      S_RD_INTERMEDIATE_POINTER_HI: if (acc_done) begin
        intermediate_pointer_next[23:16] = rd_word[7:0];
        state_next       = S_RD_SCB_OFS;
      end
      S_RD_SCB_OFS: if (acc_done) begin
        scb_ofs_next = rd_word;
        state_next   = S_RD_BASE_LO;
      end
      S_RD_BASE_LO: if (acc_done) begin
        base_next[15:0] = rd_word;
        state_next      = S_RD_BASE_HI;
      end
      S_RD_BASE_HI: if (acc_done) begin
        base_next[23:16] = rd_word[7:0];
        state_next       = S_WR_BUSY;
      end
      S_WR_BUSY: if (acc_done) begin
        pend_next[STAT_CX]  = 1'b1;
        pend_next[STAT_CNR] = 1'b1;
        clrcmd_next = 1'b1;
        cu_acc_next = 1'b1;
        ru_acc_next = 1'b1;
        state_next  = S_INT_LOW;
      end
      S_CA_IDLE: begin
        if (ca_latched) begin
          state_next = S_RD_CMD;
        end else if (pend_reg != rep_reg) begin
          clrcmd_next = 1'b0;
          state_next  = S_INT_LOW;
        end
      end
      S_RD_CMD: if (acc_done) begin
        cmd_next    = rd_word;
        pend_next   = pend_reg & ~rd_word[15:12];
        cu_acc_next = 1'b0;
        ru_acc_next = 1'b0;
        state_next  = S_ACCEPT;
      end
      S_ACCEPT: begin
        if (!cu_acc_reg && !cu_busy) begin
          cu_acc_next = 1'b1;
          cuv_next    = 1'b1;
        end
        if (!ru_acc_reg && !ru_busy) begin
          ru_acc_next = 1'b1;
          ruv_next    = 1'b1;
        end
        if (cu_acc_reg && ru_acc_reg) begin
          clrcmd_next = 1'b1;
          state_next  = S_INT_LOW;
        end
      end
      S_INT_LOW: begin
        int_next   = 1'b0;
        state_next = S_WR_STAT;
      end
      S_WR_STAT: if (acc_done) begin
        rep_next   = op_reg.wdata[15:12];
        state_next = clrcmd_reg ? S_WR_CMD : S_INT_HIGH;
      end
      S_WR_CMD: if (acc_done) state_next = S_INT_HIGH;
      S_INT_HIGH: begin
        int_next   = |pend_reg;
        state_next = S_CA_IDLE;
      end
      default: state_next = S_RESET_WAIT;
    endcase
    pend_next = pend_next | unit_events;                   // set wins over ack
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= S_RESET_WAIT;
      op_reg      <= '0;
      cmd_reg     <= '0;
      cfg_reg     <= CFG_RESET;
      intermediate_pointer_reg    <= '0;
      base_reg    <= '0;
      scb_ofs_reg <= '0;
      data_reg    <= '0;
      pend_reg    <= '0;
      rep_reg     <= '0;
      req_reg     <= 1'b0;
      half_reg    <= 1'b0;
      bus8_reg    <= 1'b1;
      int_reg     <= 1'b0;
      busreq_reg  <= 1'b0;
      clrcmd_reg  <= 1'b0;
      cu_acc_reg  <= 1'b0;
      ru_acc_reg  <= 1'b0;
      cuv_reg     <= 1'b0;
      ruv_reg     <= 1'b0;
      bcast_reg   <= 1'b1;
      fifo_reg    <= 1'b0;
      rdy_s1_reg  <= 1'b0;
      rdy_s2_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      cmd_reg     <= cmd_next;
      cfg_reg     <= cfg_next;
      intermediate_pointer_reg    <= intermediate_pointer_next;
      base_reg    <= base_next;
      scb_ofs_reg <= scb_ofs_next;
      data_reg    <= data_next;
      pend_reg    <= pend_next;
      rep_reg     <= rep_next;
      req_reg     <= req_next;
      half_reg    <= half_next;
      bus8_reg    <= bus8_next;
      int_reg     <= int_next;
      busreq_reg  <= busreq_next;
      clrcmd_reg  <= clrcmd_next;
      cu_acc_reg  <= cu_acc_next;
      ru_acc_reg  <= ru_acc_next;
      cuv_reg     <= cuv_next;
      ruv_reg     <= ruv_next;
      bcast_reg   <= bcast_next;
      fifo_reg    <= fifo_next;
      rdy_s1_reg  <= mem_rdy;
      rdy_s2_reg  <= rdy_s1_reg;
    end
  end

  assign bus_req        = busreq_reg;
  assign mem_req        = req_reg;
  assign mem_op         = op_reg;
  assign int_out        = int_reg;
  assign cu_cmd_valid   = cuv_reg;
  assign cu_cmd         = cmd_reg.cu_cmd;
  assign ru_cmd_valid   = ruv_reg;
  assign ru_cmd         = cmd_reg.ru_cmd;
  assign bus8_mode      = bus8_reg;
  assign cfg_out        = cfg_reg;
  assign broadcast_only = bcast_reg;
  assign fifo_xfer_req  = fifo_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_int_drop;
    state_reg == S_INT_LOW ##1 !int_reg && state_reg == S_WR_STAT;
  endsequence

  property p_int_order;
    $rose(int_reg) |-> $past(state_reg) == S_INT_HIGH && $past(rep_reg) == rep_reg;
  endproperty
  a_int_order: assert property (p_int_order)
    else $error("interrupt raised outside status sequence");

  property p_int_drop;
    state_reg == S_INT_LOW |-> s_int_drop;
  endproperty
  a_int_drop: assert property (p_int_drop)
    else $error("status written with interrupt high");

  property p_root_fetch;
    req_reg && state_reg == S_RD_BUS_WIDTH_SELECT |-> op_reg.addr == ROOT_ADDR && op_reg.byte_op;
  endproperty
  a_root_fetch: assert property (p_root_fetch)
    else $error("first fetch not a byte read of the root pointer");

  property p_width;
    state_reg == S_RD_BUS_WIDTH_SELECT && acc_done |=> bus8_reg == $past(mem_rdata[0]);
  endproperty
  a_width: assert property (p_width)
    else $error("bus width not taken from width byte");

  property p_busy_clear;
    req_reg && state_reg == S_WR_BUSY |-> op_reg.we && op_reg.byte_op
                                          && op_reg.wdata[7:0] == BUSY_CLEAR;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy byte not cleared with a byte write");

  property p_cmd_clear;
    req_reg && state_reg == S_WR_CMD |-> cu_acc_reg && ru_acc_reg && op_reg.we;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("command word cleared before acceptance");

  property p_bus_held;
    req_reg |-> busreq_reg;
  endproperty
  a_bus_held: assert property (p_bus_held)
    else $error("memory access without bus request");

  property p_fifo;
    fifo_level >= cfg_reg.fifo_limit |=> fifo_reg && busreq_reg;
  endproperty
  a_fifo: assert property (p_fifo)
    else $error("fifo threshold did not request the bus");

  property p_bcast;
    ia_loaded |=> !bcast_reg;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast filter kept after address load");

  property p_cu_wait;
    cuv_reg |-> $past(!cu_busy) && $past(state_reg) == S_ACCEPT;
  endproperty
  a_cu_wait: assert property (p_cu_wait)
    else $error("command passed while unit busy");

endmodule // lhiac_ctl

//--- lhiac_host_mem.sv
/*
  Host side memory model: root pointer, intermediate pointer, control block.
  Assumes the controller holds mem_req and mem_op until ready is seen.
*/
`timescale 1ns/1ps
module lhiac_host_mem
  import lhiac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        bus_req,
  input  wire logic        mem_req,
  input  wire lhiac_mem_s  mem_op,
  input  wire logic [15:0] cmd_word,
  output logic             bus_grant,
  output logic             mem_rdy,
  output logic [15:0]      mem_rdata
);
  logic [15:0] last;
  logic [1:0]  cnt;
  logic        slow;
  function automatic logic [15:0] rd(input logic [23:0] a);
    case (a)
      24'hfffffc: rd = 16'h1000;
      24'h001000: rd = 16'h5501; // busy byte set before first strobe
      24'h001002: rd = 16'h0010; // even offsets only
      24'h001004: rd = 16'h2000;
      24'h002012: rd = cmd_word;
      default:    rd = 16'h0000;
    endcase
  endfunction
  // released data bus shows the inverse of the last word
  assign mem_rdata = mem_rdy ? last : ~last;
  always @(negedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {bus_grant, mem_rdy, cnt, slow, last} <= '0;
    end else begin
      bus_grant <= bus_req; // grant never withdrawn mid sequence
      cnt <= (mem_req && !mem_rdy) ? cnt + 2'h1 : 2'h0;
      if (!mem_req) begin
        mem_rdy <= 1'b0;
      end else if (!mem_rdy && cnt >= {slow, 1'b0}) begin
        mem_rdy <= 1'b1;
        last <= rd(mem_op.addr);
        slow <= ~slow;
      end
    end
  end
endmodule // lhiac_host_mem

//--- test_lan_host_init_attention_ctl.sv
/*
  Self-checking bench for lhiac_ctl with a host memory model.
  Assumes the design file and the package are compiled first.
*/
`timescale 1ns/1ps
module test_lan_host_init_attention_ctl;
  import lhiac_pkg::*;
  logic core_clk = 0, sys_rst = 1, channel_attention = 1, cu_busy = 0, ru_busy = 0;
  logic cfg_load = 0, ia_loaded = 0, svc = 0, cu_seen, ru_seen, rdy_q = 0;
  logic [2:0] cu_state, ru_state, exp_cu, exp_ru;
  logic [3:0] unit_events = 0, fifo_level = 0, pend = 0;
  logic [15:0] cmd_word = 0, mem_rdata;
  lhiac_cfg_s cfg_in = '0, cfg_out;
  lhiac_mem_s mem_op;
  logic bus_grant, mem_rdy, bus_req, mem_req, int_out, cu_cmd_valid, ru_cmd_valid;
  logic [2:0] cu_cmd, ru_cmd;
  logic bus8_mode, broadcast_only, fifo_xfer_req;
  logic [40:0] exp_q[$];
  int fails = 0, n_checks = 0, seed = 60960, n_acc = 0, i;
  always #2.5 core_clk = ~core_clk;
  lhiac_ctl u_lhiac_ctl (.core_clk(core_clk), .sys_rst(sys_rst),
    .channel_attention(channel_attention), .bus_grant(bus_grant), .mem_rdy(mem_rdy),
    .mem_rdata(mem_rdata), .cu_busy(cu_busy), .ru_busy(ru_busy), .cu_state(cu_state),
    .ru_state(ru_state), .unit_events(unit_events), .cfg_load(cfg_load), .cfg_in(cfg_in),
    .ia_loaded(ia_loaded), .fifo_level(fifo_level), .bus_req(bus_req), .mem_req(mem_req),
    .mem_op(mem_op), .int_out(int_out), .cu_cmd_valid(cu_cmd_valid), .cu_cmd(cu_cmd),
    .ru_cmd_valid(ru_cmd_valid), .ru_cmd(ru_cmd), .bus8_mode(bus8_mode), .cfg_out(cfg_out),
    .broadcast_only(broadcast_only), .fifo_xfer_req(fifo_xfer_req));
  lhiac_host_mem u_lhiac_host_mem (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .mem_req(mem_req), .mem_op(mem_op), .cmd_word(cmd_word), .bus_grant(bus_grant),
    .mem_rdy(mem_rdy), .mem_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // compare, wait, strobe, expectation, service and closing helpers
  // ----------------------------------------------------------------
  task automatic check(string what, logic [40:0] exp, logic [40:0] got);
    n_checks++;
    if (exp !== got) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_done();
    for (i = 0; i < 2000 && (exp_q.size() != 0 || bus_req !== 1'b0); i++) @(negedge core_clk);
    check("sequence end", 0, 41'(exp_q.size()) | 41'(bus_req));
    if (i == 2000) finish_test();
  endtask
  task automatic pulse_ca();
    @(negedge core_clk) channel_attention = 1'b0;
    repeat (3) @(negedge core_clk);
    channel_attention = 1'b1;
  endtask
  task automatic expect_stat();
    exp_q.push_back({24'h002010, 1'b0, pend, 1'b0, cu_state, 1'b0, ru_state, 4'h0});
  endtask
  task automatic service(logic [3:0] ack, logic [2:0] cu, logic [2:0] ru);
    cmd_word = {ack, 1'b0, cu, 1'b0, ru, 4'h0}; // units idle while host edits
    pend = pend & ~ack;
    {exp_cu, exp_ru, cu_seen, ru_seen, svc} = {cu, ru, 3'b001};
    expect_stat();
    exp_q.push_back({24'h002012, 17'h0});
    {cu_busy, ru_busy} = 2'b11;
    pulse_ca(); // previous command word already cleared
    repeat (20) @(negedge core_clk);
    cu_busy = 1'b0;
    repeat (9) @(negedge core_clk);
    ru_busy = 1'b0;
    wait_done();
    check("int after service", 41'(|pend), 41'(int_out));
    check("both units", 2'b11, {cu_seen, ru_seen});
    svc = 1'b0;
    $display("service done cu %0d ru %0d", cu, ru);
  endtask
  // ----------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    rdy_q <= mem_rdy;
    if (cu_cmd_valid) begin
      cu_seen = 1'b1;
      check("cu_cmd", {exp_cu, 1'b0}, {cu_cmd, cu_busy});
    end
    if (ru_cmd_valid) begin
      ru_seen = 1'b1;
      check("ru_cmd", {exp_ru, 1'b0}, {ru_cmd, ru_busy});
    end
    if (mem_req && mem_rdy && !rdy_q) begin
      n_acc++;
      if (n_acc == 1) check("first access", {24'hfffff6, 2'b10}, {mem_op.addr, mem_op.byte_op, mem_op.we});
      if (mem_op.we && mem_op.addr == 24'h002010) check("int at status", 0, 41'(int_out));
      if (mem_op.we && svc && mem_op.addr == 24'h002012) check("accepted", 2'b11, {cu_seen, ru_seen});
      if (mem_op.we && exp_q.size() == 0) check("unexpected write", 0, 1);
      else if (mem_op.we) check("write", exp_q.pop_front(), {mem_op.addr, mem_op.byte_op,
        mem_op.byte_op ? {8'h0, mem_op.wdata[7:0]} : mem_op.wdata});
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {cu_state, ru_state} = 6'($random(seed));
    repeat (20) @(negedge core_clk);
    check("reset outputs", {1'b1, 1'b1, CFG_RESET, 2'b00}, {bus8_mode, broadcast_only, cfg_out, int_out, bus_req});
    sys_rst = 1'b0;
    $display("reset done");
    pend = 4'b1010;
    exp_q.push_back({24'h001000, 1'b1, 16'h0});
    expect_stat();
    exp_q.push_back({24'h002012, 17'h0});
    pulse_ca();
    wait_done();
    check("init end", 2'b10, {int_out, bus8_mode});
    $display("init done");
    service(4'b1010, 3'h1, 3'h4);
    @(negedge core_clk) unit_events = 4'b0100;
    @(negedge core_clk) unit_events = 4'b0000;
    pend = 4'b0100;
    expect_stat();
    wait_done();
    check("event int", 1, 41'(int_out));
    $display("event done");
    cfg_in = 9'($random(seed)) | 9'h100;
    @(negedge core_clk) {cfg_load, ia_loaded} = 2'b11;
    @(negedge core_clk) {cfg_load, ia_loaded} = 2'b00;
    fifo_level = cfg_in.fifo_limit;
    repeat (3) @(negedge core_clk);
    check("cfg_out", cfg_in, cfg_out);
    check("broadcast_only", 0, 41'(broadcast_only));
    check("fifo at limit", 1, 41'(fifo_xfer_req));
    fifo_level = cfg_in.fifo_limit - 4'h1;
    repeat (3) @(negedge core_clk);
    check("fifo below limit", 0, 41'(fifo_xfer_req));
    $display("config done");
    for (int k = 2; k < 8; k++) service(4'b0100 & 4'(k << 1), 3'(k), 3'(9 - k));
    finish_test();
  end
endmodule // test_lan_host_init_attention_ctl
